// [design/cbwd_lat_timer.sv]
// initiator latency timer counted in secondary-bus clock cycles
// assumes cclk and the strobes are synchronous to aclk
`timescale 1ns/10ps
module cbwd_lat_timer
    import cbwd_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    // control
    input  wire logic [7:0] latency,
    input  wire logic       cclk,
    input  wire logic       init_start,
    input  wire logic       data_phase_done,
    input  wire logic       xfer_done,
    // state
    output logic [7:0]      count,
    output logic            expired,
    output logic            terminate
);

    typedef struct packed {
        logic [7:0] count;
        logic       busy;
        logic       cclk_q;
        logic       expired;
        logic       terminate;
    } cbwd_lat_state_t;

    cbwd_lat_state_t s;
    cbwd_lat_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.cclk_q = cclk;
        next_s.terminate = 1'b0;
        if (init_start) begin
            next_s.count = latency;
            next_s.busy = 1'b1;
            next_s.expired = (latency == RST_BUS);
        end else if (s.busy) begin
            if (cclk && !s.cclk_q && s.count != RST_BUS) begin
                next_s.count = s.count - 8'h01;
                next_s.expired = (s.count == 8'h01);
            end
            // expiry only cuts the transfer at a data phase boundary
            if (s.expired && data_phase_done) begin
                next_s.terminate = 1'b1;
                next_s.busy = 1'b0;
            end else if (xfer_done) begin
                next_s.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign count = s.count;
    assign expired = s.expired;
    assign terminate = s.terminate;

    chk_lat_load_value: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && init_start |=> s.count == $past(latency) && s.busy)
        else $error("latency count not loaded at start");

    chk_lat_term_phase: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && s.busy && s.expired && data_phase_done && !init_start
        |=> terminate && !s.busy)
        else $error("expired transfer not ended at data phase");

endmodule : cbwd_lat_timer

// [design/cbwd_top.sv]
// bus number, latency timer and memory window decode for a bridge
// assumes AXI4-Lite register access and one clock, aclk
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps

// Behaviour
// - an 8-bit rw primary bus number register resets to zero.
// - an 8-bit rw secondary bus number register resets to zero.
// - an 8-bit rw subordinate bus number register resets to zero.
// - config forwarding compares the target bus with all three.
// - starting an initiator frame loads a latency count of cclk cycles.
// - on expiry the transfer ends when the next data phase completes.
// - window base and limit bits 31 to 12 are read/write.
// - window bits 11 to 0 read as zero and ignore writes.
// - each window has its own prefetchable control bit.
// - a window claims nothing while its base and limit are both zero.
// - windows steer primary memory down and secondary cycles outside them up.
module cbwd_top
    import cbwd_pkg::*;
(
    // clock, reset, enable
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    // register bus
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // configuration decode
    input  wire cbwd_cfg_req_t cfg_req,
    output cbwd_cfg_dec_t      cfg_dec,
    // memory decode
    input  wire cbwd_mem_req_t pri_mem,
    output cbwd_mem_dec_t      pri_dec,
    input  wire cbwd_mem_req_t sec_mem,
    output logic               sec_fwd_up,
    // secondary initiator
    input  wire logic          cclk,
    input  wire logic          init_start,
    input  wire logic          data_phase_done,
    input  wire logic          xfer_done,
    output logic               lat_expired,
    output logic               lat_terminate
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic          awready;
        logic          wready;
        logic          arready;
        logic          aw_held;
        logic          w_held;
        logic [7:0]    awaddr;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic [7:0]    pri;
        logic [7:0]    sec;
        logic [7:0]    sub;
        logic [7:0]    lat;
        logic [31:0]   w0b;
        logic [31:0]   w0l;
        logic [31:0]   w1b;
        logic [31:0]   w1l;
        logic          pf0;
        logic          pf1;
        cbwd_cfg_dec_t cfg_dec;
        cbwd_mem_dec_t pri_dec;
        logic          sec_fwd_up;
    } cbwd_top_state_t;

    cbwd_top_state_t s;
    cbwd_top_state_t next_s;
    logic [7:0]      lat_count;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic win_en(input logic [31:0] base,
                                    input logic [31:0] limit);
        return (base != RST_WIN) || (limit != RST_WIN);
    endfunction : win_en

    function automatic logic in_win(input logic [31:0] addr,
                                    input logic [31:0] base,
                                    input logic [31:0] limit);
        return win_en(base, limit) && addr >= base
            && addr <= (limit | WIN_ONES);
    endfunction : in_win

    function automatic logic [31:0] strb_win(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return v & WIN_MASK;
    endfunction : strb_win

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic hit0;
        logic hit1;
        logic up0;
        logic up1;
        hit0 = 1'b0;
        hit1 = 1'b0;
        up0 = 1'b0;
        up1 = 1'b0;
        next_s = s;

        // write address and data may arrive in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_held && next_s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            case (next_s.awaddr)
                ADDR_PRI: begin
                    if (next_s.wstrb[0]) begin
                        next_s.pri = next_s.wdata[7:0];
                    end
                end
                ADDR_SEC: begin
                    if (next_s.wstrb[0]) begin
                        next_s.sec = next_s.wdata[7:0];
                    end
                end
                ADDR_SUB: begin
                    if (next_s.wstrb[0]) begin
                        next_s.sub = next_s.wdata[7:0];
                    end
                end
                ADDR_LAT: begin
                    if (next_s.wstrb[0]) begin
                        next_s.lat = next_s.wdata[7:0];
                    end
                end
                ADDR_W0B: begin
                    next_s.w0b = strb_win(s.w0b, next_s.wdata,
                                          next_s.wstrb);
                end
                ADDR_W0L: begin
                    next_s.w0l = strb_win(s.w0l, next_s.wdata,
                                          next_s.wstrb);
                end
                ADDR_W1B: begin
                    next_s.w1b = strb_win(s.w1b, next_s.wdata,
                                          next_s.wstrb);
                end
                ADDR_W1L: begin
                    next_s.w1l = strb_win(s.w1l, next_s.wdata,
                                          next_s.wstrb);
                end
                ADDR_CTRL: begin
                    if (next_s.wstrb[1]) begin
                        next_s.pf0 = next_s.wdata[PF0_BIT];
                        next_s.pf1 = next_s.wdata[PF1_BIT];
                    end
                end
                ADDR_STAT: begin
                    next_s.bresp = RESP_OKAY;
                end
                default: begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // read channel: one read in flight, answered the next cycle
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                ADDR_PRI:  next_s.rdata[7:0] = s.pri;
                ADDR_SEC:  next_s.rdata[7:0] = s.sec;
                ADDR_SUB:  next_s.rdata[7:0] = s.sub;
                ADDR_LAT:  next_s.rdata[7:0] = s.lat;
                ADDR_W0B:  next_s.rdata = s.w0b;
                ADDR_W0L:  next_s.rdata = s.w0l;
                ADDR_W1B:  next_s.rdata = s.w1b;
                ADDR_W1L:  next_s.rdata = s.w1l;
                ADDR_CTRL: begin
                    next_s.rdata[PF0_BIT] = s.pf0;
                    next_s.rdata[PF1_BIT] = s.pf1;
                end
                ADDR_STAT: begin
                    next_s.rdata[7:0] = lat_count;
                    next_s.rdata[STAT_EXP] = lat_expired;
                end
                default: next_s.rresp = RESP_SLVERR;
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // configuration forwarding, own bus number never forwarded
        next_s.cfg_dec.valid = cfg_req.valid;
        next_s.cfg_dec.fwd = cfg_req.valid && cfg_req.bus != s.pri
            && cfg_req.bus >= s.sec && cfg_req.bus <= s.sub;
        next_s.cfg_dec.type0 = next_s.cfg_dec.fwd
            && cfg_req.bus == s.sec;

        // window 0 wins where the two windows overlap
        hit0 = in_win(pri_mem.addr, s.w0b, s.w0l);
        hit1 = in_win(pri_mem.addr, s.w1b, s.w1l);
        next_s.pri_dec.claim = pri_mem.valid && (hit0 || hit1);
        next_s.pri_dec.win = pri_mem.valid && !hit0 && hit1;
        next_s.pri_dec.prefetch = pri_mem.valid
            && (hit0 ? s.pf0 : (hit1 && s.pf1));
        up0 = in_win(sec_mem.addr, s.w0b, s.w0l);
        up1 = in_win(sec_mem.addr, s.w1b, s.w1l);
        next_s.sec_fwd_up = sec_mem.valid && !up0 && !up1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // latency timer
    // ****************************************************************
    // too small a value cuts most bursts short; software's concern
    cbwd_lat_timer u_lat (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce              (ce),
        .latency         (s.lat),
        .cclk            (cclk),
        .init_start      (init_start),
        .data_phase_done (data_phase_done),
        .xfer_done       (xfer_done),
        .count           (lat_count),
        .expired         (lat_expired),
        .terminate       (lat_terminate)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign cfg_dec       = s.cfg_dec;
    assign pri_dec       = s.pri_dec;
    assign sec_fwd_up    = s.sec_fwd_up;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_bus_reset_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> s.pri == RST_BUS && s.sec == RST_BUS
            && s.sub == RST_BUS)
        else $error("bus numbers not zero after reset");

    chk_sec_write_lands: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && next_s.bvalid && !s.bvalid
            && next_s.awaddr == ADDR_SEC && next_s.wstrb[0]
        |=> s.sec == $past(next_s.wdata[7:0]) && s_axi_bvalid)
        else $error("secondary bus number write lost");

    chk_cfg_fwd_range: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && cfg_req.valid && cfg_req.bus == s.sub
            && s.sub >= s.sec && s.sub != s.pri
        |=> cfg_dec.fwd)
        else $error("config cycle to subordinate not forwarded");

    chk_cfg_own_bus: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && cfg_req.valid && cfg_req.bus == s.pri |=> !cfg_dec.fwd)
        else $error("config cycle to primary bus forwarded");

    chk_win_low_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ((s.w0b | s.w0l | s.w1b | s.w1l) & WIN_ONES) == RST_WIN)
        else $error("window low bits not zero");

    chk_win_off_claim: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && (s.w0b | s.w0l | s.w1b | s.w1l) == RST_WIN
        |=> !pri_dec.claim)
        else $error("disabled window claimed a cycle");

    chk_prefetch_sel: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce ##1 pri_dec.claim && !pri_dec.win
        |-> pri_dec.prefetch == $past(s.pf0))
        else $error("window 0 prefetch bit not applied");

    chk_win_limit_top: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && pri_mem.valid && s.w0b != RST_WIN && s.w0l >= s.w0b
            && pri_mem.addr == (s.w0l | WIN_ONES)
        |=> pri_dec.claim && !pri_dec.win)
        else $error("top of window 0 not claimed");

    chk_bresp_holds: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");

endmodule : cbwd_top

// [include/cbwd_pkg.sv]
// constants and types shared by the bridge decode block
// assumes a 32-bit AXI4-Lite register bus and one clock domain
package cbwd_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_PRI  = 8'h18;
    localparam logic [7:0] IDX_SEC  = 8'h19;
    localparam logic [7:0] IDX_SUB  = 8'h1a;
    localparam logic [7:0] IDX_LAT  = 8'h1b;
    localparam logic [7:0] IDX_W0B  = 8'h1c;
    localparam logic [7:0] IDX_W0L  = 8'h20;
    localparam logic [7:0] IDX_W1B  = 8'h24;
    localparam logic [7:0] IDX_W1L  = 8'h28;
    localparam logic [7:0] IDX_CTRL = 8'h3e;
    localparam logic [7:0] IDX_STAT = 8'h3f;

    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_PRI  = {IDX_PRI[5:0], 2'h0};
    localparam logic [7:0] ADDR_SEC  = {IDX_SEC[5:0], 2'h0};
    localparam logic [7:0] ADDR_SUB  = {IDX_SUB[5:0], 2'h0};
    localparam logic [7:0] ADDR_LAT  = {IDX_LAT[5:0], 2'h0};
    localparam logic [7:0] ADDR_W0B  = {IDX_W0B[5:0], 2'h0};
    localparam logic [7:0] ADDR_W0L  = {IDX_W0L[5:0], 2'h0};
    localparam logic [7:0] ADDR_W1B  = {IDX_W1B[5:0], 2'h0};
    localparam logic [7:0] ADDR_W1L  = {IDX_W1L[5:0], 2'h0};
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'h0};
    localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'h0};

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam logic [7:0]  RST_BUS    = 8'h00;
    localparam logic [31:0] RST_WIN    = 32'h0000_0000;
    localparam logic [31:0] WIN_MASK   = 32'hffff_f000;
    localparam logic [31:0] WIN_ONES   = 32'h0000_0fff;
    localparam int          PF0_BIT    = 8;
    localparam int          PF1_BIT    = 9;
    localparam int          STAT_EXP   = 8;
    localparam logic [7:0]  LAT_REC    = 8'h20;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       valid;
        logic [7:0] bus;
    } cbwd_cfg_req_t;

    typedef struct packed {
        logic valid;
        logic fwd;
        logic type0;
    } cbwd_cfg_dec_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } cbwd_mem_req_t;

    typedef struct packed {
        logic claim;
        logic win;
        logic prefetch;
    } cbwd_mem_dec_t;

endpackage : cbwd_pkg

// [test/cbwd_far_model.sv]
// far-side initiator model: frames one transfer and makes cclk
// assumes go is held high for one aclk cycle by the bench
`timescale 1ns/10ps
module cbwd_far_model (
    // clock and command
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] edges,
    // secondary bus strobes
    output logic            cclk,
    output logic            init_start,
    output logic            data_phase_done,
    output logic            xfer_done,
    output logic            done
);
    initial begin
        {cclk, init_start, data_phase_done, xfer_done, done} = 5'h00;
        forever begin
            @(posedge aclk);
            if (go === 1'b1) begin
                init_start <= 1'b1;
                @(posedge aclk);
                init_start <= 1'b0;
                // cclk runs only inside the frame, still outside it
                repeat (edges) begin
                    cclk <= 1'b1;
                    repeat (2) @(posedge aclk);
                    cclk <= 1'b0;
                    repeat (2) @(posedge aclk);
                end
                data_phase_done <= 1'b1;
                @(posedge aclk);
                data_phase_done <= 1'b0;
                xfer_done       <= 1'b1;
                done            <= 1'b1;
                @(posedge aclk);
                xfer_done <= 1'b0;
                done      <= 1'b0;
            end
        end
    end
endmodule : cbwd_far_model

// [test/cbwd_top_tb.sv]
// bench for the bridge decode block: registers, decodes, timer
// assumes cbwd_far_model drives the secondary initiator strobes
`timescale 1ns/10ps
module cbwd_top_tb;
    import cbwd_pkg::*;
    logic          aclk = 0, aresetn = 0, ce = 1, go = 0;
    logic [7:0]    awa = 0, ara = 0, edges = 0, b, pri, sec, sub;
    logic          awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
    logic [31:0]   wd = 0, rdat, a;
    logic [3:0]    ws = 0;
    logic          awr, wr_rdy, bv, arr, rv, up, cclk, ist, dpd, xd;
    logic          lexp, lterm, fdone;
    logic [1:0]    br, rr, pf;
    cbwd_cfg_req_t cfg = '0;
    cbwd_cfg_dec_t cdec;
    cbwd_mem_req_t pm = '0, sm = '0;
    cbwd_mem_dec_t pdec;
    logic [31:0]   wb [2], wl [2];
    int            error_cnt = 0, samples_checked = 0, n_term = 0;
    localparam logic [7:0] RA [8] = '{ADDR_PRI, ADDR_SEC, ADDR_SUB,
        ADDR_LAT, ADDR_W0B, ADDR_W0L, ADDR_W1B, ADDR_W1L};

    cbwd_top i_cbwd_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .cfg_req(cfg),
        .cfg_dec(cdec), .pri_mem(pm), .pri_dec(pdec), .sec_mem(sm),
        .sec_fwd_up(up), .cclk(cclk), .init_start(ist),
        .data_phase_done(dpd), .xfer_done(xd), .lat_expired(lexp),
        .lat_terminate(lterm));
    cbwd_far_model i_cbwd_far_model (.aclk(aclk), .go(go), .edges(edges),
        .cclk(cclk), .init_start(ist), .data_phase_done(dpd),
        .xfer_done(xd), .done(fdone));

    initial forever #2 aclk = ~aclk;
    always @(negedge aclk) if (lterm === 1'b1) n_term++;

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic tmo(input bit hit);
        if (hit) begin
            error_cnt++;
            wrap_up();
        end
    endtask : tmo
    task automatic wait_hi(ref logic s);
        int n;
        for (n = 0; n < 500 && s !== 1'b1; n++) @(negedge aclk);
        tmo(n == 500);
    endtask : wait_hi
    task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        bit ta, tw;
        @(posedge aclk);
        awa  <= ad;
        wd   <= d;
        ws   <= s;
        awv  <= 1'b1;
        wv   <= 1'b1;
        brdy <= 1'b1;
        {ta, tw} = 2'b00;
        for (int n = 0; !(ta && tw); n++) begin
            tmo(n == 64);
            @(negedge aclk);
            ta = ta | (awr === 1'b1);
            tw = tw | (wr_rdy === 1'b1);
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        wait_hi(bv);
        r = br;
        @(posedge aclk);
        brdy <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e,
                        input logic [1:0] er);
        @(posedge aclk);
        ara  <= ad;
        arv  <= 1'b1;
        rrdy <= 1'b1;
        wait_hi(arr);
        @(posedge aclk);
        arv <= 1'b0;
        wait_hi(rv);
        chk(rdat, e);
        chk(32'(rr), 32'(er));
        @(posedge aclk);
        rrdy <= 1'b0;
    endtask : rchk

    // ****************************************************************
    // expectations and decode stimulus
    // ****************************************************************
    function automatic logic [31:0] emem(input logic [31:0] x);
        logic [1:0] h;
        for (int i = 0; i < 2; i++)
            h[i] = (wb[i] != 0 || wl[i] != 0) && x >= wb[i]
                   && x <= (wl[i] | WIN_ONES);
        return 32'({h != 0, h == 2'b10, h[0] ? pf[0] : h[1] & pf[1],
                    h == 2'b00});
    endfunction : emem
    task automatic dec(input logic [7:0] bn, input logic [31:0] x);
        logic f;
        @(posedge aclk);
        cfg <= '{1'b1, bn};
        pm  <= '{1'b1, x};
        sm  <= '{1'b1, x};
        @(posedge aclk);
        @(negedge aclk);
        f = bn != pri && bn >= sec && bn <= sub;
        chk(32'(cdec), 32'({1'b1, f, f && bn == sec}));
        chk(32'({pdec, up}), emem(x));
    endtask : dec
    task automatic run(input logic [7:0] e);
        @(posedge aclk);
        go    <= 1'b1;
        edges <= e;
        @(posedge aclk);
        go <= 1'b0;
        wait_hi(fdone);
        // let the terminate pulse be counted before anyone looks
        @(negedge aclk);
    endtask : run

    initial begin
        logic [31:0] v [8];
        logic [31:0] m;
        logic [1:0]  r;
        int          s;
        s = $urandom(60309);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        {pri, sec, sub, pf} = '0;
        wb = '{0, 0};
        wl = '{0, 0};
        foreach (RA[k]) rchk(RA[k], 32'h0, RESP_OKAY);
        dec(8'h00, 32'h0000_0000);
        pri = 8'($urandom());
        sec = 8'($urandom());
        sub = sec + 8'($urandom_range(6));
        for (int i = 0; i < 2; i++) begin
            wb[i] = $urandom() & WIN_MASK;
            wl[i] = (wb[i] + $urandom_range(32'h3000)) & WIN_MASK;
        end
        v = '{pri, sec, sub, LAT_REC, wb[0], wl[0], wb[1], wl[1]};
        foreach (RA[k]) begin
            m = k < 4 ? 32'hff : WIN_MASK;
            wr(RA[k], v[k] | ($urandom() & ~m), 4'hf, r);
            chk(32'(r), 32'(RESP_OKAY));
            rchk(RA[k], v[k], RESP_OKAY);
        end
        pf = 2'($urandom());
        wr(ADDR_CTRL, {22'h0, pf, 8'h00}, 4'h2, r);
        rchk(ADDR_CTRL, {22'h0, pf, 8'h00}, RESP_OKAY);
        wr(8'h04, 32'hffff_ffff, 4'hf, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rchk(8'h04, 32'h0, RESP_SLVERR);
        for (int k = 0; k < 60; k++) begin
            b = k < 6 ? v[k % 3] + 8'(k / 3) : 8'($urandom());
            a = k < 6 ? (k < 3 ? wb[k % 2] : wl[k % 2] | WIN_ONES)
                      : wb[k % 2] + ($urandom() & 32'h7fff) - 32'h1000;
            dec(b, a);
        end
        // clock enable low: decode output must hold its last value
        m = 32'(cdec);
        @(posedge aclk);
        ce  <= 1'b0;
        cfg <= '0;
        repeat (3) @(negedge aclk);
        chk(32'(cdec), m);
        @(posedge aclk);
        ce <= 1'b1;
        run(8'h21);
        chk(32'(lexp), 32'h1);
        chk(32'(n_term), 32'h1);
        rchk(ADDR_STAT, 32'h100, RESP_OKAY);
        run(8'h10);
        chk(32'(lexp), 32'h0);
        chk(n_term, 32'h1);
        rchk(ADDR_STAT, 32'h10, RESP_OKAY);
        wrap_up();
    end
endmodule : cbwd_top_tb
